/* verilog/sgp_consts.svh */
// register map, field positions, command codes and reset values for the shared pin block
`ifndef SGP_CONSTS_SVH
`define SGP_CONSTS_SVH

`define SGP_EXT_PREFIX 4'hF
`define SGP_WADDR_CFG 4'h1
`define SGP_WADDR_LEVEL 4'h2
`define SGP_RADDR_CFG 5'h1C
`define SGP_RADDR_LEVEL 5'h1D

`define SGP_CFG_IO4_ALEN 0
`define SGP_CFG_IO4_DIR 1
`define SGP_CFG_IO4_POL 2
`define SGP_CFG_IO3_ALEN 4
`define SGP_CFG_IO3_DIR 5
`define SGP_CFG_IO3_POL 6
`define SGP_CFG_IO3_FSEL 7

`define SGP_LVL_IO4 4
`define SGP_LVL_IO3 5

`define SGP_CFG_WMASK 8'hF7
`define SGP_LVL_WMASK 8'hF0
`define SGP_CFG_RESET 8'h00
`define SGP_LVL_RESET 8'h00

`endif

/* verilog/sgp_pkg.sv */
// types shared by the shared pin block modules
package sgp_pkg;

  // pin configuration register as stored
  typedef struct packed {
    logic io3_function_select;
    logic io3_polarity;
    logic io3_direction;
    logic io3_alert_enable;
    logic unused3;
    logic io4_polarity;
    logic io4_direction;
    logic io4_alert_enable;
  } sgp_cfg_t;

  // pin data register as stored
  typedef struct packed {
    logic io1_level;
    logic io2_level;
    logic io3_level;
    logic io4_level;
    logic [3:0] unused;
  } sgp_level_t;

  // one pin cell state
  typedef struct packed {
    logic oe;
    logic out;
    logic alert;
  } sgp_cell_state_t;

  // top-level state
  typedef struct packed {
    sgp_cfg_t cfg;
    sgp_level_t level;
    logic [11:0] rd_data;
    logic rd_valid;
    logic alert;
    logic aux_select;
  } sgp_state_t;

endpackage : sgp_pkg

/* verilog/sgp_pin_cell.sv */
// one general-purpose pin: drive, direction and alert detection
`timescale 1ns/1ps

module sgp_pin_cell
  import sgp_pkg::*;
(
  input wire logic i_clock,
  input wire logic i_rst,
  input wire logic i_enable,
  input wire logic i_direction,
  input wire logic i_polarity,
  input wire logic i_alert_enable,
  input wire logic i_level,
  input wire logic i_pin,
  output logic o_oe,
  output logic o_out,
  output logic o_alert
);

  sgp_cell_state_t state_reg;
  sgp_cell_state_t state_next;

  // direction 0 drives, 1 listens; alert only while listening and unmasked
  always_comb begin
    state_next = state_reg;
    state_next.oe = i_enable & ~i_direction;
    state_next.out = i_level;
    state_next.alert = i_enable & i_direction & i_alert_enable & (i_pin == i_polarity);
  end

  // state register, cleared so the pin does not drive while reset is held
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  assign o_oe = state_reg.oe;
  assign o_out = state_reg.out;
  assign o_alert = state_reg.alert;

  default clocking cb @(posedge i_clock); endclocking
  default disable iff (i_rst);

  a_cell_drive: assert property (o_oe |-> $past(i_enable) && !$past(i_direction))
    else $error("pin driven while configured as input");
  a_cell_alert_level: assert property (o_alert |-> $past(i_pin) == $past(i_polarity))
    else $error("alert raised at inactive level");
  a_cell_alert_mask: assert property (!i_alert_enable |=> !o_alert)
    else $error("alert raised while masked");

endmodule : sgp_pin_cell

/* verilog/sgp_shared_io.sv */
// configuration and data registers for shared pins 3 and 4
// Operation
// - config bit 0 set lets shared_io_4 raise alert; cleared masks it.
// - config bit 4 set lets shared_io_3 raise alert; cleared masks it.
// - config bit 1 is shared_io_4 direction: 0 output, 1 input.
// - config bit 5 is shared_io_3 direction: 0 output, 1 input.
// - config bit 2 is shared_io_4 active level: 0 low, 1 high.
// - config bit 6 is shared_io_3 active level: 0 low, 1 high.
// - config bit 7 picks analog input (0) or shared_io_3 (1).
// - config written at extended address F1, read at address 11100.
// - level register written at F2, read at 11101; bits 4-7 hold pins 4,3,2,1.
// - both registers reset to zero.
// - config bit 3 and level bits 0-3 ignore writes.
`timescale 1ns/1ps
`include "sgp_consts.svh"

module sgp_shared_io
  import sgp_pkg::*;
(
  input wire logic i_clock,
  input wire logic i_rst,
  input wire logic i_wr_valid,
  input wire logic [15:0] i_wr_word,
  input wire logic i_rd_valid,
  input wire logic [4:0] i_rd_addr,
  output logic [11:0] o_rd_data,
  output logic o_rd_valid,
  input wire logic i_io3_in,
  output logic o_io3_out,
  output logic o_io3_oe,
  input wire logic i_io4_in,
  output logic o_io4_out,
  output logic o_io4_oe,
  output logic o_aux_select,
  output logic o_alert
);

  sgp_state_t state_reg;
  sgp_state_t state_next;
  logic io3_alert;
  logic io4_alert;
  logic wr_ext;
  logic wr_cfg;
  logic wr_level;
  logic [7:0] level_view;

  // decode of the extended write word
  always_comb begin
    wr_ext = i_wr_valid && (i_wr_word[15:12] == `SGP_EXT_PREFIX);
    wr_cfg = wr_ext && (i_wr_word[11:8] == `SGP_WADDR_CFG);
    wr_level = wr_ext && (i_wr_word[11:8] == `SGP_WADDR_LEVEL);
  end

  // readback of the level register: input pins show the pin, outputs the stored bit
  always_comb begin
    level_view = state_reg.level;
    if (state_reg.cfg.io4_direction) begin
      level_view[`SGP_LVL_IO4] = i_io4_in;
    end
    if (state_reg.cfg.io3_function_select && state_reg.cfg.io3_direction) begin
      level_view[`SGP_LVL_IO3] = i_io3_in;
    end
  end

  // next-state logic for registers, read port and alert
  always_comb begin
    state_next = state_reg;
    state_next.rd_valid = 1'b0;
    if (wr_cfg) begin
      state_next.cfg = i_wr_word[7:0] & `SGP_CFG_WMASK;
    end
    if (wr_level) begin
      state_next.level = i_wr_word[7:0] & `SGP_LVL_WMASK;
    end
    if (i_rd_valid) begin
      state_next.rd_valid = 1'b1;
      case (i_rd_addr)
        `SGP_RADDR_CFG: state_next.rd_data = {4'h0, state_reg.cfg};
        `SGP_RADDR_LEVEL: state_next.rd_data = {4'h0, level_view};
        default: state_next.rd_data = 12'h000;
      endcase
    end
    // 0 routes the pin to the analog input, so the cell is held idle
    state_next.aux_select = ~state_reg.cfg.io3_function_select;
    state_next.alert = io3_alert | io4_alert;
  end

  // state register; synchronous clear gives all-zero registers
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  // shared_io_3 only works when selected as a general pin
  sgp_pin_cell u_io3 (
    .i_clock(i_clock),
    .i_rst(i_rst),
    .i_enable(state_reg.cfg.io3_function_select),
    .i_direction(state_reg.cfg.io3_direction),
    .i_polarity(state_reg.cfg.io3_polarity),
    .i_alert_enable(state_reg.cfg.io3_alert_enable),
    .i_level(state_reg.level.io3_level),
    .i_pin(i_io3_in),
    .o_oe(o_io3_oe),
    .o_out(o_io3_out),
    .o_alert(io3_alert)
  );

  // shared_io_4 is a dedicated general pin
  sgp_pin_cell u_io4 (
    .i_clock(i_clock),
    .i_rst(i_rst),
    .i_enable(1'b1),
    .i_direction(state_reg.cfg.io4_direction),
    .i_polarity(state_reg.cfg.io4_polarity),
    .i_alert_enable(state_reg.cfg.io4_alert_enable),
    .i_level(state_reg.level.io4_level),
    .i_pin(i_io4_in),
    .o_oe(o_io4_oe),
    .o_out(o_io4_out),
    .o_alert(io4_alert)
  );

  // outputs straight from the state register
  assign o_rd_data = state_reg.rd_data;
  assign o_rd_valid = state_reg.rd_valid;
  assign o_aux_select = state_reg.aux_select;
  assign o_alert = state_reg.alert;

  default clocking cb @(posedge i_clock); endclocking
  default disable iff (i_rst);

  a_cfg_write: assert property (wr_cfg |=> state_reg.cfg == ($past(i_wr_word[7:0]) & 8'hF7))
    else $error("config write not stored");
  a_unused_bits: assert property (state_reg.cfg.unused3 == 1'b0 && state_reg.level.unused == 4'h0)
    else $error("unused bits took a write");
  a_cfg_read: assert property (i_rd_valid && i_rd_addr == 5'h1C
      |=> o_rd_valid && o_rd_data == {4'h0, $past(state_reg.cfg)})
    else $error("config readback wrong");
  a_level_read: assert property (i_rd_valid && i_rd_addr == 5'h1D && !state_reg.cfg.io4_direction
      |=> o_rd_data[4] == $past(state_reg.level.io4_level))
    else $error("level readback wrong");
  a_io4_drive: assert property (wr_cfg && !i_wr_word[1] && !wr_level |=> ##1 o_io4_oe)
    else $error("shared_io_4 not driven as output");
  a_io3_dir: assert property (wr_cfg && i_wr_word[7] && !i_wr_word[5] |=> ##1 o_io3_oe)
    else $error("shared_io_3 not driven as output");
  // both the cell and the route flag take the same select one edge later
  a_io3_aux: assert property (!state_reg.cfg.io3_function_select
      |=> !o_io3_oe && o_aux_select)
    else $error("analog pin driven");
  a_alert_io4: assert property (state_reg.cfg.io4_direction && state_reg.cfg.io4_alert_enable
      && i_io4_in == state_reg.cfg.io4_polarity && $stable(state_reg.cfg) |=> ##1 o_alert)
    else $error("alert missed on shared_io_4");
  a_alert_io3_mask: assert property (!state_reg.cfg.io3_alert_enable && !state_reg.cfg.io4_alert_enable
      |=> ##1 !o_alert)
    else $error("alert while both masked");
  a_reset_zero: assert property (disable iff (1'b0) $past(i_rst) |-> state_reg.cfg == 8'h00
      && state_reg.level == 8'h00)
    else $error("registers not cleared by reset");

  // write port: each register moves only on its own write, masked bits stay zero
  a_level_write: assert property (wr_level
      |=> state_reg.level == ($past(i_wr_word[7:0]) & 8'hF0))
    else $error("level write not stored");
  a_cfg_hold: assert property (!wr_cfg
      |=> $stable(state_reg.cfg))
    else $error("config changed without a write");
  a_level_hold: assert property (!wr_level
      |=> $stable(state_reg.level))
    else $error("level changed without a write");

  // read port: one-cycle valid, data stands between reads, unmapped reads answer zero
  a_rd_pulse: assert property (!i_rd_valid
      |=> !o_rd_valid)
    else $error("read valid without a request");
  a_rd_hold: assert property (!i_rd_valid
      |=> $stable(o_rd_data))
    else $error("read data moved without a request");
  a_rd_unmapped: assert property (i_rd_valid && i_rd_addr != 5'h1C && i_rd_addr != 5'h1D
      |=> o_rd_valid && o_rd_data == 12'h000)
    else $error("unmapped read not zero");

  // level readback: input pins show the live pin, the rest the stored bits
  a_io4_view: assert property (i_rd_valid && i_rd_addr == 5'h1D && state_reg.cfg.io4_direction
      |=> o_rd_data[4] == $past(i_io4_in))
    else $error("shared_io_4 input level not read back");
  a_io3_view: assert property (i_rd_valid && i_rd_addr == 5'h1D
      && state_reg.cfg.io3_function_select && state_reg.cfg.io3_direction
      |=> o_rd_data[5] == $past(i_io3_in))
    else $error("shared_io_3 input level not read back");
  a_io3_stored_view: assert property (i_rd_valid && i_rd_addr == 5'h1D
      && !(state_reg.cfg.io3_function_select && state_reg.cfg.io3_direction)
      |=> o_rd_data[5] == $past(state_reg.level.io3_level))
    else $error("shared_io_3 stored level not read back");
  a_upper_view: assert property (i_rd_valid && i_rd_addr == 5'h1D
      |=> o_rd_data[7:6] == $past(state_reg.level[7:6]) && o_rd_data[3:0] == 4'h0
      && o_rd_data[11:8] == 4'h0)
    else $error("level readback upper or unused bits wrong");

  // pin drive follows the registers one edge later; the edge right after reset is skipped
  a_io4_out: assert property (!$past(i_rst)
      |-> o_io4_out == $past(state_reg.level.io4_level))
    else $error("shared_io_4 drive value wrong");
  a_io3_out: assert property (!$past(i_rst)
      |-> o_io3_out == $past(state_reg.level.io3_level))
    else $error("shared_io_3 drive value wrong");
  a_io4_input: assert property (state_reg.cfg.io4_direction
      |=> !o_io4_oe)
    else $error("shared_io_4 driven while input");
  a_io3_input: assert property (state_reg.cfg.io3_direction
      |=> !o_io3_oe)
    else $error("shared_io_3 driven while input");
  a_aux_follow: assert property (!$past(i_rst)
      |-> o_aux_select == !$past(state_reg.cfg.io3_function_select))
    else $error("analog route does not follow function select");

  // alert: only enabled input pins may raise it, two edges after the pin
  a_alert_io3: assert property (state_reg.cfg.io3_function_select && state_reg.cfg.io3_direction
      && state_reg.cfg.io3_alert_enable && i_io3_in == state_reg.cfg.io3_polarity
      |=> ##1 o_alert)
    else $error("alert missed on shared_io_3");
  a_alert_outputs: assert property (!state_reg.cfg.io4_direction
      && !(state_reg.cfg.io3_function_select && state_reg.cfg.io3_direction)
      |=> ##1 !o_alert)
    else $error("alert raised with no input pin");

  c_cfg_write: cover property (wr_cfg);
  c_level_read: cover property (i_rd_valid && i_rd_addr == 5'h1D);
  c_alert: cover property (o_alert);
  c_io3_drive: cover property (o_io3_oe);

endmodule : sgp_shared_io

/* dv/sgp_host_model.sv */
// host model: extended-map register writes and read-address requests
`timescale 1ns/1ps

module sgp_host_model (
  input wire logic i_clock,
  output logic o_wr_valid,
  output logic [15:0] o_wr_word,
  output logic o_rd_valid,
  output logic [4:0] o_rd_addr,
  input wire logic [11:0] i_rd_data,
  input wire logic i_rd_valid
);
  // idle bus at power-up
  initial begin
    o_wr_valid = 1'b0;
    o_wr_word = 16'h0000;
    o_rd_valid = 1'b0;
    o_rd_addr = 5'h00;
  end

  // one word per strobe; word inverted after release so stale data never looks valid
  task wr(input logic [3:0] pre, input logic [3:0] adr, input logic [7:0] dat);
    @(posedge i_clock);
    #1;
    o_wr_valid = 1'b1;
    o_wr_word = {pre, adr, dat};
    @(posedge i_clock);
    #1;
    o_wr_valid = 1'b0;
    o_wr_word = ~o_wr_word;
  endtask : wr

  // read address strobe, answer taken one cycle later
  task rd(input logic [4:0] adr, output logic [11:0] dat, output logic vld);
    @(posedge i_clock);
    #1;
    o_rd_valid = 1'b1;
    o_rd_addr = adr;
    @(posedge i_clock);
    #1;
    o_rd_valid = 1'b0;
    o_rd_addr = ~adr;
    vld = i_rd_valid;
    dat = i_rd_data;
  endtask : rd
endmodule : sgp_host_model

/* dv/sgp_shared_io_tb.sv */
// self-checking bench for the shared pin 3/4 block
`timescale 1ns/1ps

module sgp_shared_io_tb;
  logic i_clock = 1'b0;
  logic i_rst = 1'b1;
  logic wr_v, rd_v, rv, a_sel, alert, o3, e3, o4, e4, d3 = 1'b0, d4 = 1'b0;
  logic [15:0] ww;
  logic [4:0] ra;
  logic [11:0] rdat;
  int error_cnt = 0;
  int cmp_count = 0;
  int cyc = 0;
  // pin wire: design drive wins while enabled, else bench level
  wire logic p3 = e3 ? o3 : d3;
  wire logic p4 = e4 ? o4 : d4;

  always #2 i_clock = ~i_clock;

  sgp_host_model sgp_host_model_inst (.i_clock(i_clock), .o_wr_valid(wr_v), .o_wr_word(ww), .o_rd_valid(rd_v),
    .o_rd_addr(ra), .i_rd_data(rdat), .i_rd_valid(rv));

  sgp_shared_io sgp_shared_io_inst (.i_clock(i_clock), .i_rst(i_rst), .i_wr_valid(wr_v), .i_wr_word(ww),
    .i_rd_valid(rd_v), .i_rd_addr(ra), .o_rd_data(rdat), .o_rd_valid(rv), .i_io3_in(p3), .o_io3_out(o3),
    .o_io3_oe(e3), .i_io4_in(p4), .o_io4_out(o4), .o_io4_oe(e4), .o_aux_select(a_sel), .o_alert(alert));

  task complete_run;
    $display("errors %0d compares %0d", error_cnt, cmp_count);
    if (error_cnt == 0 && cmp_count > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : complete_run

  // hang guard, far above the run length
  always @(posedge i_clock) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      error_cnt++;
      complete_run();
    end
  end

  task chk(input logic [11:0] seen, input logic [11:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      error_cnt++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  // read one address and compare valid flag and data
  task rchk(input logic [4:0] adr, input logic [11:0] exp);
    logic [11:0] d;
    logic v;
    sgp_host_model_inst.rd(adr, d, v);
    chk({11'h000, v}, 12'h001);
    chk(d, exp);
  endtask : rchk

  task settle;
    repeat (3) @(posedge i_clock);
    #1;
  endtask : settle

  // reset values and unmapped read
  task t_reset;
    settle();
    chk({11'h000, a_sel}, 12'h001);
    rchk(5'h1C, 12'h000);
    rchk(5'h1D, 12'h000);
    rchk(5'h1B, 12'h000);
  endtask : t_reset

  // unused bits ignore writes, bad prefix ignored
  task t_masks;
    d3 = 1'b1;
    d4 = 1'b1;
    sgp_host_model_inst.wr(4'hF, 4'h1, 8'hFF);
    sgp_host_model_inst.wr(4'hE, 4'h1, 8'h00);
    rchk(5'h1C, 12'h0F7);
    settle();
    chk({11'h000, a_sel}, 12'h000);
    sgp_host_model_inst.wr(4'hF, 4'h2, 8'hFF);
    rchk(5'h1D, 12'h0F0);
  endtask : t_masks

  // both pins driven as outputs
  task t_outputs;
    sgp_host_model_inst.wr(4'hF, 4'h1, 8'h80);
    sgp_host_model_inst.wr(4'hF, 4'h2, 8'h20);
    settle();
    chk({8'h00, e3, o3, e4, o4}, 12'h00E);
    rchk(5'h1D, 12'h020);
  endtask : t_outputs

  // alert enable of shared_io_4 and active levels of both pins
  task t_alert;
    d3 = 1'b0;
    d4 = 1'b0;
    sgp_host_model_inst.wr(4'hF, 4'h1, 8'hF7);
    settle();
    chk({11'h000, alert}, 12'h000);
    d4 = 1'b1;
    settle();
    chk({11'h000, alert}, 12'h001);
    sgp_host_model_inst.wr(4'hF, 4'h1, 8'hF6);
    settle();
    chk({11'h000, alert}, 12'h000);
    d3 = 1'b1;
    settle();
    chk({11'h000, alert}, 12'h001);
    sgp_host_model_inst.wr(4'hF, 4'h1, 8'hB6);
    settle();
    chk({11'h000, alert}, 12'h000);
    sgp_host_model_inst.wr(4'hF, 4'h1, 8'h03);
    d4 = 1'b0;
    settle();
    chk({11'h000, alert}, 12'h001);
    sgp_host_model_inst.wr(4'hF, 4'h1, 8'h01);
    settle();
    chk({11'h000, alert}, 12'h000);
  endtask : t_alert

  // main sequence
  initial begin
    repeat (4) @(posedge i_clock);
    #1;
    i_rst = 1'b0;
    t_reset();
    t_masks();
    t_outputs();
    t_alert();
    complete_run();
  end
endmodule : sgp_shared_io_tb
